// ===== lkd_host_model.sv
// Host controller model for the three-wire serial link of the scanner.
// Assumes the bench resolves the shared data line with a pull-up.
module lkd_host_model (
    // Serial link
    output logic      frame_select_strobe,
    output logic      sclk,
    output logic      drive_low,
    input  wire logic line
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Frame tasks
    // ************************************************************
    // Clock idles high and stands still outside frames
    initial begin
        frame_select_strobe = 1'b1;
        sclk                = 1'b1;
        drive_low           = 1'b0;
    end

    task automatic start();
        frame_select_strobe <= 1'b0;
        #300;
    endtask

    task automatic stop();
        #1000;
        drive_low           <= 1'b0;
        frame_select_strobe <= 1'b1;
        #1000;
    endtask

    task automatic put(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            sclk      <= 1'b0;
            drive_low <= ~b[i];
            #100;
            sclk      <= 1'b1;
            #100;
        end
    endtask

    // Sampled late in the high phase: the bit holds until the next fall
    task automatic get(output logic [7:0] b);
        drive_low <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            sclk <= 1'b0;
            #100;
            sclk <= 1'b1;
            #90;
            b[i] = line;
            #10;
        end
    endtask
endmodule

// ===== lkd_pkg.sv
// Constants, state encodings and timing counts of the LED display key scanner.
// Assumes a 40 MHz pclk; host serial pins are asynchronous to it.
//
// Summary of operation
// - With strobe low, data line shifts in on each rising serial clock edge.
// - During reads, output bits change on falling serial clock edges.
// - Eight received bits form a byte that is then decoded and executed.
// - Strobe falling starts a transaction and clears the bit counter.
// - Strobe rising mid-byte drops partial bits; configuration stays unchanged.
// - Shared data line is open drain; device only pulls low or releases.
// - Reset clears control state, blanks display, floats outputs, enters low power.
// - Low power keeps configured data; outputs resume when operation resumes.
// - Outputs not acting as digit or segment drivers stay high impedance.
// - Frame order: key scan, discrete LED slot, then digit slots three to eight.
// - Key scan: grids off, segments zero to seven enabled singly, 64 us each.
// - Key returns sampled 60 us after each segment turns on, latched.
// - Any key change against previous state drives the low interrupt level.
// - Each interrupt half clears only after the read byte holding its key bits completes.
// - Grid off in first and last steps; 32 us blanking around grid switching.
// - LED slot: LED grid only, each segment on for fourteen minus off steps.
// - Digit slots enable grids in turn, on time one to fourteen steps.
// - Digit slots stop at configured digit count, then frame restarts.
// - Display off skips digit slots and returns straight to key scan.
// - Key data is two bytes, one bit per scan line, sent LSB first.
// - Both key bytes reset to zero and follow the pressed key state.
// - First complete byte after strobe falls is a command; later bytes data.
// - Display on flag resets to zero, so the display starts off.
package lkd_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_MHZ    = 40;
    localparam int unsigned STEP_US    = 64;
    localparam int unsigned SAMPLE_US  = 60;
    localparam int unsigned BLANK_US   = 32;
    localparam int unsigned STEP_CYC   = STEP_US * CLK_MHZ;
    localparam int unsigned SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
    localparam int unsigned BLANK_CYC  = BLANK_US * CLK_MHZ;
    localparam logic [3:0]  LAST_STEP  = 4'hF;
    localparam logic [3:0]  MAX_ON     = 4'hE;

    // ************************************************************
    // APB register map
    // ************************************************************
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam int unsigned CTRL_LP    = 3;
    localparam logic [2:0]  DIGITS_RST = 3'h6;

    // ************************************************************
    // Serial command fields and memory map
    // ************************************************************
    localparam int unsigned CMD_READ   = 6;
    localparam int unsigned CMD_FIXED  = 5;
    localparam logic [4:0]  CMD_DISPON = 5'h0D;
    localparam logic [4:0]  CMD_DISPOF = 5'h0E;
    localparam logic [1:0]  BANK_FONT  = 2'h0;
    localparam logic [1:0]  BANK_LED   = 2'h1;
    localparam logic [1:0]  BANK_SBRI  = 2'h2;
    localparam logic [1:0]  BANK_LBRI  = 2'h3;
    localparam logic [2:0]  ADDR_LED   = 3'h0;
    localparam logic [2:0]  ADDR_KEY_RETURN_A  = 3'h1;
    localparam logic [2:0]  ADDR_KEY_RETURN_B  = 3'h2;
    localparam logic [7:0]  SBRI_RST   = 8'hFB;

    typedef enum logic [2:0] {
        LKD_SL_KEY = 3'b001,
        LKD_SL_LED = 3'b010,
        LKD_SL_DIG = 3'b100
    } lkd_slot_t;

endpackage

// ===== lkd_scanner.sv
// Display timing, key matrix scanner and three-wire serial port.
// Assumes serial pins and key returns are asynchronous and sampled by pclk;
// data line needs an external pull-up.
module lkd_scanner #(
    parameter int unsigned NUM_DIGITS = 6
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host serial link
    input  wire logic        frame_select_strobe,
    input  wire logic        serial_clk,
    input  wire logic        sdio_in,
    output logic             sdio_out,
    output logic             sdio_oe,
    output logic             key_irq_n,
    // Key matrix and LED drivers
    input  wire logic        key_return_a,
    input  wire logic        key_return_b,
    output logic      [7:0]  seg_out,
    output logic      [7:0]  seg_oe,
    output logic      [5:0]  grid_out,
    output logic      [5:0]  grid_oe,
    output logic             discrete_led_digit_output,
    output logic             discrete_led_digit_oe
);

    if (NUM_DIGITS < 1 || NUM_DIGITS > 6) begin : g_chk
        $error("NUM_DIGITS must be 1 to 6");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [4:0]        s1;
        logic [4:0]        s2;
        logic [1:0]        prev;
        logic [31:0][7:0]  mem;
        logic [7:0]        rx;
        logic [2:0]        bitcnt;
        logic              first;
        logic              rd;
        logic              fixed;
        logic [4:0]        ptr;
        logic [7:0]        tx;
        logic              dbit;
        logic              disp_on;
        logic              lp;
        logic              ctrl_lp;
        logic [2:0]        digits;
        logic [15:0]       keys;
        logic              chg0;
        logic              chg1;
        lkd_pkg::lkd_slot_t slot;
        logic [11:0]       sub;
        logic [3:0]        step;
        logic [2:0]        idx;
        logic [7:0]        seg_oe;
        logic [5:0]        grid_oe;
        logic              led_oe;
        logic              irq_n;
        logic [31:0]       prdata;
        logic              smp;
    } lkd_state_t;

    lkd_state_t q;
    lkd_state_t n;

    function automatic logic [7:0] rd_byte(input logic [4:0] p, input logic [15:0] k,
                                           input logic [7:0] m);
        if (p == {lkd_pkg::BANK_LED, lkd_pkg::ADDR_KEY_RETURN_A}) return k[7:0];
        if (p == {lkd_pkg::BANK_LED, lkd_pkg::ADDR_KEY_RETURN_B}) return k[15:8];
        return m;
    endfunction

    // Grid window: steps 1..on, turn-on delayed by the blanking interval
    function automatic logic gwin(input logic [3:0] st, input logic [11:0] sb,
                                  input logic [3:0] on);
        return st >= 4'h1 && st <= on && !(st == 4'h1 && sb < 12'(lkd_pkg::BLANK_CYC));
    endfunction

    // Segments also drop one blanking interval before the grid turns off
    function automatic logic swin(input logic [3:0] st, input logic [11:0] sb,
                                  input logic [3:0] on);
        return gwin(st, sb, on)
            && !(st == on && sb >= 12'(lkd_pkg::STEP_CYC - lkd_pkg::BLANK_CYC));
    endfunction

    logic       stb_hi;
    logic       stb_fall;
    logic       clk_rise;
    logic       clk_fall;
    logic       apb_acc;
    logic       mapped;
    assign stb_hi   = q.s2[0];
    assign stb_fall = q.prev[0] & ~q.s2[0];
    assign clk_rise = ~q.prev[1] & q.s2[1];
    assign clk_fall = q.prev[1] & ~q.s2[1];
    assign apb_acc  = psel & penable;
    assign mapped   = paddr == lkd_pkg::REG_CTRL || paddr == lkd_pkg::REG_STATUS;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [7:0] byte_v;
        logic [4:0] p_inc;
        logic [3:0] on_s;
        logic [3:0] off_s;
        logic [7:0] ldat;
        logic       last_sub;
        byte_v   = {q.s2[2], q.rx[7:1]};
        p_inc    = q.fixed ? q.ptr : {q.ptr[4:3], q.ptr[2:0] + 3'h1};
        on_s     = 4'h0;
        off_s    = 4'h0;
        ldat     = q.mem[{lkd_pkg::BANK_LED, lkd_pkg::ADDR_LED}];
        last_sub = q.sub == 12'(lkd_pkg::STEP_CYC - 1);
        n        = q;
        // Two-flop synchronisers; edges are taken from the second stage
        n.s1     = {key_return_b, key_return_a, sdio_in, serial_clk, frame_select_strobe};
        n.s2     = q.s1;
        n.prev   = q.s2[1:0];
        n.smp    = 1'b0;

        // Serial port
        if (stb_hi) begin
            n.bitcnt = 3'h0;
            n.rd     = 1'b0;
            n.dbit   = 1'b1;
        end else if (stb_fall) begin
            n.bitcnt = 3'h0;
            n.first  = 1'b1;
            n.rd     = 1'b0;
        end else if (clk_rise) begin
            n.rx     = byte_v;
            n.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == 3'h7) begin
                if (q.first) begin
                    n.first = 1'b0;
                    if (!byte_v[lkd_pkg::CMD_READ] && byte_v[4:0] == lkd_pkg::CMD_DISPON) begin
                        n.disp_on = 1'b1;
                        n.lp      = 1'b0;
                    end else if (!byte_v[lkd_pkg::CMD_READ]
                                 && byte_v[4:0] == lkd_pkg::CMD_DISPOF) begin
                        n.disp_on = 1'b0;
                    end else begin
                        n.rd    = byte_v[lkd_pkg::CMD_READ];
                        n.fixed = byte_v[lkd_pkg::CMD_FIXED];
                        n.ptr   = byte_v[4:0];
                        n.tx    = rd_byte(byte_v[4:0], q.keys, q.mem[byte_v[4:0]]);
                    end
                end else if (q.rd) begin
                    // Interrupt half clears only when its key byte completes
                    if (q.ptr == {lkd_pkg::BANK_LED, lkd_pkg::ADDR_KEY_RETURN_A}) begin
                        n.chg0 = 1'b0;
                    end
                    if (q.ptr == {lkd_pkg::BANK_LED, lkd_pkg::ADDR_KEY_RETURN_B}) begin
                        n.chg1 = 1'b0;
                    end
                    n.ptr = p_inc;
                    n.tx  = rd_byte(p_inc, q.keys, q.mem[p_inc]);
                end else begin
                    n.mem[q.ptr] = byte_v;
                    n.lp         = 1'b0;
                    n.ptr        = p_inc;
                end
            end
        end else if (clk_fall && q.rd) begin
            n.dbit = q.tx[q.bitcnt];
        end

        // Timing generator; low power holds it at the start of key scan but keeps memory intact
        if (q.lp || q.ctrl_lp) begin
            n.sub  = 12'h000;
            n.step = 4'h0;
            n.idx  = 3'h0;
            n.slot = lkd_pkg::LKD_SL_KEY;
        end else begin
            n.sub = last_sub ? 12'h000 : q.sub + 12'h001;
            case (q.slot)
                lkd_pkg::LKD_SL_KEY: begin
                    if (q.sub == 12'(lkd_pkg::SAMPLE_CYC - 1)) begin
                        n.smp                 = 1'b1;
                        n.keys[{1'b0, q.idx}] = q.s2[3];
                        n.keys[{1'b1, q.idx}] = q.s2[4];
                        // Set placed after the clear so a coincident change wins
                        if (q.s2[3] != q.keys[{1'b0, q.idx}]) begin
                            n.chg0 = 1'b1;
                        end
                        if (q.s2[4] != q.keys[{1'b1, q.idx}]) begin
                            n.chg1 = 1'b1;
                        end
                    end
                    if (last_sub) begin
                        n.idx = q.idx + 3'h1;
                        if (q.idx == 3'h7) begin
                            n.slot = lkd_pkg::LKD_SL_LED;
                        end
                    end
                end
                lkd_pkg::LKD_SL_LED: begin
                    if (last_sub) begin
                        n.step = q.step + 4'h1;
                        if (q.step == lkd_pkg::LAST_STEP) begin
                            n.idx  = 3'h0;
                            n.slot = q.disp_on ? lkd_pkg::LKD_SL_DIG
                                               : lkd_pkg::LKD_SL_KEY;
                        end
                    end
                end
                lkd_pkg::LKD_SL_DIG: begin
                    if (last_sub) begin
                        n.step = q.step + 4'h1;
                        if (q.step == lkd_pkg::LAST_STEP) begin
                            n.idx = q.idx + 3'h1;
                            if (q.idx + 3'h1 >= q.digits || !q.disp_on) begin
                                n.idx  = 3'h0;
                                n.slot = lkd_pkg::LKD_SL_KEY;
                            end
                        end
                    end
                end
                default: n.slot = lkd_pkg::LKD_SL_KEY;
            endcase
        end
        n.irq_n = ~(n.chg0 | n.chg1);

        // Output enables; anything not driving stays floating
        n.seg_oe  = 8'h00;
        n.grid_oe = 6'h00;
        n.led_oe  = 1'b0;
        if (!q.lp && !q.ctrl_lp) begin
            case (q.slot)
                lkd_pkg::LKD_SL_KEY: n.seg_oe = 8'h01 << q.idx;
                lkd_pkg::LKD_SL_LED: begin
                    if (ldat != 8'h00) begin
                        n.led_oe = gwin(q.step, q.sub, lkd_pkg::MAX_ON);
                        for (int i = 0; i < 8; i++) begin
                            off_s = q.mem[{lkd_pkg::BANK_LBRI, 3'(i / 2)}][(i % 2) * 4 +: 4];
                            on_s  = off_s > lkd_pkg::MAX_ON ? 4'h0 : lkd_pkg::MAX_ON - off_s;
                            n.seg_oe[i] = ldat[i] & swin(q.step, q.sub, on_s);
                        end
                    end
                end
                lkd_pkg::LKD_SL_DIG: begin
                    on_s = q.mem[{lkd_pkg::BANK_SBRI, 3'h0}][3:0];
                    if (on_s == 4'h0) begin
                        on_s = 4'h1;
                    end else if (on_s > lkd_pkg::MAX_ON) begin
                        on_s = lkd_pkg::MAX_ON;
                    end
                    if (q.disp_on) begin
                        n.grid_oe[q.idx] = gwin(q.step, q.sub, on_s);
                        n.seg_oe = q.mem[{lkd_pkg::BANK_FONT, q.idx}]
                                 & {8{swin(q.step, q.sub, on_s)}};
                    end
                end
                default: n.seg_oe = 8'h00;
            endcase
        end

        // APB: read data is captured in the setup cycle
        if (psel && !penable) begin
            if (paddr == lkd_pkg::REG_CTRL) begin
                n.prdata = {28'h0, q.ctrl_lp, q.digits};
            end else if (paddr == lkd_pkg::REG_STATUS) begin
                n.prdata = {10'h0, q.slot, q.lp, q.disp_on, ~q.irq_n, q.keys};
            end else begin
                n.prdata = 32'h0;
            end
        end
        if (apb_acc && pwrite && paddr == lkd_pkg::REG_CTRL) begin
            n.ctrl_lp = pwdata[lkd_pkg::CTRL_LP];
            if (pwdata[2:0] != 3'h0 && 32'(pwdata[2:0]) <= NUM_DIGITS) begin
                n.digits = pwdata[2:0];
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q                                      <= '0;
            q.s1                                   <= 5'h1F;
            q.s2                                   <= 5'h1F;
            q.prev                                 <= 2'h3;
            q.dbit                                 <= 1'b1;
            q.irq_n                                <= 1'b1;
            q.lp                                   <= 1'b1;
            q.digits                               <= 3'(NUM_DIGITS);
            q.slot                                 <= lkd_pkg::LKD_SL_KEY;
            q.mem[{lkd_pkg::BANK_SBRI, 3'h0}]      <= lkd_pkg::SBRI_RST;
        end else begin
            q <= n;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata   = q.prdata;
    assign pready   = 1'b1;
    assign pslverr  = apb_acc & ~mapped;
    assign sdio_out = 1'b0;
    assign sdio_oe  = q.rd & ~stb_hi & ~q.dbit;
    assign key_irq_n                 = q.irq_n;
    assign seg_out                   = 8'h00;
    assign seg_oe                    = q.seg_oe;
    assign grid_out                  = 6'h3F;
    assign grid_oe                   = q.grid_oe;
    assign discrete_led_digit_output = 1'b1;
    assign discrete_led_digit_oe     = q.led_oe;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_stb_clears_count: assert property (@(posedge pclk) disable iff (!presetn)
        stb_fall |=> q.bitcnt == 3'h0 && q.first)
        else $error("strobe fall did not restart the byte");
    a_partial_dropped: assert property (@(posedge pclk) disable iff (!presetn)
        stb_hi |=> q.mem == $past(q.mem) && q.bitcnt == 3'h0)
        else $error("partial byte changed state");
    a_drive_only_read: assert property (@(posedge pclk) disable iff (!presetn)
        sdio_oe |-> q.rd && !stb_hi && !q.first)
        else $error("data line driven outside a read");
    a_lp_floats: assert property (@(posedge pclk) disable iff (!presetn)
        (q.lp || q.ctrl_lp) ##1 (q.lp || q.ctrl_lp)
        |-> seg_oe == 8'h00 && grid_oe == 6'h00 && !discrete_led_digit_oe)
        else $error("output enabled in low power");
    a_key_grid_off: assert property (@(posedge pclk) disable iff (!presetn)
        q.slot == lkd_pkg::LKD_SL_KEY |=> grid_oe == 6'h00 && !discrete_led_digit_oe
        && $countones(seg_oe) <= 1)
        else $error("grid on during key scan");
    a_sample_point: assert property (@(posedge pclk) disable iff (!presetn)
        q.smp |-> $past(q.sub) == 12'(lkd_pkg::SAMPLE_CYC - 1)
        && $past(q.slot) == lkd_pkg::LKD_SL_KEY)
        else $error("key sample off its 60 us point");
    a_irq_on_change: assert property (@(posedge pclk) disable iff (!presetn)
        q.smp && q.keys != $past(q.keys) |-> !key_irq_n)
        else $error("key change without interrupt");
    a_off_skips: assert property (@(posedge pclk) disable iff (!presetn)
        q.slot == lkd_pkg::LKD_SL_LED && !q.disp_on && !q.lp && !q.ctrl_lp
        ##1 q.slot != lkd_pkg::LKD_SL_LED |-> q.slot == lkd_pkg::LKD_SL_KEY)
        else $error("digit slots entered with display off");
    a_edge_steps_dark: assert property (@(posedge pclk) disable iff (!presetn)
        (q.step == 4'h0 || q.step == lkd_pkg::LAST_STEP) && q.slot != lkd_pkg::LKD_SL_KEY
        |=> grid_oe == 6'h00 && !discrete_led_digit_oe)
        else $error("grid on in a blanking step");

endmodule

// ===== lkd_scanner_tb.sv
// Self-checking bench for the display scanner: APB, serial link, key scan.
// Assumes the host model file is compiled first.
module lkd_scanner_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, st;
    logic        pready, pslverr, err, stb, sclk, host_low, sdio_out, sdio_oe;
    logic        key_irq_n, key_a = 1, key_b = 0, led_oe;
    logic [7:0]  seg_oe, b;
    logic [5:0]  grid_oe;
    int          bad_count = 0, check_count = 0, cyc = 0;
    wire         line = !(host_low || (sdio_oe && !sdio_out));

    lkd_scanner #(.NUM_DIGITS(6)) i_lkd_scanner (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_select_strobe(stb), .serial_clk(sclk), .sdio_in(line),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .key_irq_n(key_irq_n),
        .key_return_a(key_a), .key_return_b(key_b), .seg_out(), .seg_oe(seg_oe),
        .grid_out(), .grid_oe(grid_oe), .discrete_led_digit_output(),
        .discrete_led_digit_oe(led_oe));
    lkd_host_model i_lkd_host_model (.frame_select_strobe(stb), .sclk(sclk),
        .drive_low(host_low), .line(line));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        st      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic sread(input logic [7:0] cmd);
        i_lkd_host_model.start();
        i_lkd_host_model.put(cmd, 8);
        i_lkd_host_model.get(b);
        i_lkd_host_model.stop();
    endtask

    task automatic swrite(input logic [7:0] cmd, input logic [7:0] d, input int n);
        i_lkd_host_model.start();
        i_lkd_host_model.put(cmd, 8);
        i_lkd_host_model.put(d, n);
        i_lkd_host_model.stop();
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        apb(1'b0, 12'h004, 32'h0);
        check("flags", st[18:16], 3'h4);
        check("keys", st[15:0], 16'h0000);
        check("oe", {seg_oe, grid_oe, led_oe, sdio_oe, key_irq_n}, 17'h1);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped", st, 32'h0);
        check("slverr", err, 1'b1);
        apb(1'b1, 12'h000, 32'h0000000B);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl", st, 32'h0000000B);
        apb(1'b1, 12'h000, 32'h00000007);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl", st, 32'h00000003);
        $display("test reset done");
    endtask

    task automatic t_serial();
        sread(8'h50);
        check("bright", b, lkd_pkg::SBRI_RST);
        swrite(8'h10, 8'h00, 4);
        sread(8'h50);
        check("partial", b, lkd_pkg::SBRI_RST);
        $display("test serial done");
    endtask

    task automatic t_keys();
        int n;
        n = 0;
        swrite(8'h10, 8'h05, 8);
        sread(8'h50);
        check("write", b, 8'h05);
        check("scan", {seg_oe, grid_oe, led_oe}, 15'h0080);
        apb(1'b0, 12'h004, 32'h0);
        check("lp", st[21:18], 4'h2);
        while (key_irq_n !== 1'b0 && n < 25000) begin
            @(posedge pclk);
            n++;
        end
        repeat (20480) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        check("keyst", st[16:0], 17'h100FF);
        sread(8'h49);
        check("key_return_a", b, 8'hFF);
        check("irq", key_irq_n, 1'b1);
        $display("test keys done");
    endtask

    task automatic t_disp();
        // Display still off: the blank LED slot must hand back to key scan
        while (seg_oe === 8'h00) begin
            @(posedge pclk);
        end
        apb(1'b0, 12'h004, 32'h0);
        check("skip", st[21:19], 3'h1);
        swrite(8'h0D, 8'h00, 0);
        apb(1'b0, 12'h004, 32'h0);
        check("dispon", st[17], 1'b1);
        $display("test display done");
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_serial();
        t_keys();
        t_disp();
        print_verdict();
    end
endmodule
